// [verilog/nco_prog_ports.sv]
/*
  serial register port and write-only fast reconfiguration port that
  program four nco frequency and phase words.
  assumes both host clocks are far slower than clk so that every edge
  is seen after synchronising; the nco datapath picks fast or base words.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// [R1] select low for whole serial access
// [R2] sample serial input on clock rise
// [R3] access is direction, 15-bit address, byte
// [R4] first bit one reads, zero writes
// [R5] msb first, low byte at low address
// [R6] write stores last byte at address
// [R7] read drives register during last byte
// [R8] serial output released outside read data
// [R9] more bytes stream while select low
// [R10] stream address steps, direction from cfg bit
// [R11] fast port is write-only, nibble wide
// [R12] fast header: write, sync flag, address
// [R13] fast address decrements after each byte
// [R14] fast byte committed on its last nibble
// [R15] fast fields sent high nibble first
// [R16] sync flag fires event on select release
// [R17] host completes at least first data byte
// [R18] mask resets selected accumulators when enabled
// [R19] long word replaces base; upper half aliased
// [R20] short word sets only upper 32 bits
// [R21] fast phase replaces base phase when enabled; code applies it on every sync even with fast_en low
// [R22] new words wait for chosen sync event
// [R23] host holds fast select for transaction
module nco_prog_ports #(
  parameter int CFG_DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial register port pins
  input wire logic serial_clk,
  input wire logic serial_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // fast reconfiguration port pins
  input wire logic fast_clk,
  input wire logic fast_port_select_n,
  input wire logic [3:0] fast_data,
  // external sync event, clk domain pulse
  input wire logic ext_sync,
  // nco side
  output spi_fr_pkg::nco_words_t nco_words,
  output logic [spi_fr_pkg::NCO_N-1:0] nco_acc_reset,
  output logic nco_sync,
  output logic fast_active
);
  localparam int CW = $clog2(CFG_DEPTH);

  spi_fr_pkg::spi_pin_t sp;
  spi_fr_pkg::fast_pin_t fp;

  // serial group state
  spi_fr_pkg::spi_state_t spi_state_ff, nxt_spi_state;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  logic [14:0] shin_ff, nxt_shin;
  logic rd_ff, nxt_rd;
  logic [14:0] spi_addr_ff, nxt_spi_addr;
  logic [7:0] out_sh_ff, nxt_out_sh;
  logic serial_out_ff, nxt_serial_out;
  logic serial_out_oe_ff, nxt_serial_out_oe;
  logic sclk_prev_ff;
  logic [7:0] cfg_ff [CFG_DEPTH];
  logic [7:0] nxt_cfg [CFG_DEPTH];
  logic wr_stb, sclk_rise, sclk_fall, address_direction_bit;
  logic [7:0] wr_byte;
  logic [14:0] step_addr;

  // fast port group state
  logic [2:0] nib_ff, nxt_nib;
  logic hi_ff, nxt_hi;
  logic [3:0] hold_ff, nxt_hold;
  logic [13:0] fast_addr_ff, nxt_fast_addr;
  logic tsync_ff, nxt_tsync;
  logic wok_ff, nxt_wok;
  logic fclk_prev_ff, fsel_prev_ff;
  logic [spi_fr_pkg::NCO_N-1:0][7:0][7:0] pend_long_ff, nxt_pend_long;
  logic [spi_fr_pkg::NCO_N-1:0][1:0][7:0] pend_phase_ff, nxt_pend_phase;
  logic [3:0] mask_ff, nxt_mask;
  logic fclk_rise, fire, commit;
  logic [7:0] fbyte;
  logic [13:0] off;

  // apply group state
  spi_fr_pkg::nco_words_t nco_words_ff, nxt_nco_words;
  logic [3:0] acc_reset_ff, nxt_acc_reset;
  logic nco_sync_ff, sync_evt, fast_en;
  logic [1:0] src;

  // input synchronisers
  sync3 #(.W(3), .RST_VAL(3'b010)) u_spi_sync (
    .clk(clk),
    .nrst(nrst),
    .d({serial_clk, serial_select_n, serial_in}),
    .q(sp)
  );
  sync3 #(.W(6), .RST_VAL(6'b010000)) u_fast_sync (
    .clk(clk),
    .nrst(nrst),
    .d({fast_clk, fast_port_select_n, fast_data}),
    .q(fp)
  );

  function automatic logic [7:0] rd_byte(input logic [14:0] a);
    rd_byte = spi_fr_pkg::BYTE_ZERO;
    if (int'(a) < CFG_DEPTH) begin
      rd_byte = cfg_ff[a[CW-1:0]];
    end
  endfunction

  // edges and config fields
  assign sclk_rise = sp.sclk & ~sclk_prev_ff; // see [R2]
  assign sclk_fall = ~sp.sclk & sclk_prev_ff;
  assign address_direction_bit = cfg_ff[spi_fr_pkg::REG_CFG_A[CW-1:0]][spi_fr_pkg::ADDRESS_DIRECTION_BIT_POS];
  assign fast_en = cfg_ff[spi_fr_pkg::REG_CTRL[CW-1:0]][spi_fr_pkg::FAST_EN_POS];
  assign src = cfg_ff[spi_fr_pkg::REG_CTRL[CW-1:0]][spi_fr_pkg::SRC_POS +: 2];
  assign step_addr = address_direction_bit ? 15'(spi_addr_ff + spi_fr_pkg::SPI_ADDR_ONE)
                            : 15'(spi_addr_ff - spi_fr_pkg::SPI_ADDR_ONE); // see [R10]

  // serial framing, shift in and shift out
  always_comb begin
    nxt_spi_state = spi_state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shin = shin_ff;
    nxt_rd = rd_ff;
    nxt_spi_addr = spi_addr_ff;
    nxt_out_sh = out_sh_ff;
    nxt_serial_out = serial_out_ff;
    nxt_serial_out_oe = serial_out_oe_ff;
    wr_stb = 1'b0;
    wr_byte = {shin_ff[6:0], sp.sdi}; // see [R5]
    if (sp.sel_n) begin
      nxt_spi_state = spi_fr_pkg::SPI_IDLE; // see [R1]
      nxt_bit_cnt = '0;
      nxt_serial_out_oe = 1'b0;
    end else begin
      case (spi_state_ff)
        spi_fr_pkg::SPI_IDLE, spi_fr_pkg::SPI_HDR: begin
          nxt_spi_state = spi_fr_pkg::SPI_HDR;
          if (sclk_rise) begin
            nxt_shin = {shin_ff[13:0], sp.sdi};
            nxt_bit_cnt = 4'(bit_cnt_ff + spi_fr_pkg::CNT_ONE);
            if (bit_cnt_ff == spi_fr_pkg::SPI_HDR_LAST) begin
              nxt_rd = shin_ff[14]; // see [R4]
              nxt_spi_addr = {shin_ff[13:0], sp.sdi}; // see [R3]
              nxt_out_sh = rd_byte({shin_ff[13:0], sp.sdi});
              nxt_bit_cnt = '0;
              nxt_spi_state = spi_fr_pkg::SPI_DATA;
            end
          end
        end
        spi_fr_pkg::SPI_DATA: begin
          if (sclk_rise) begin
            nxt_shin = {shin_ff[13:0], sp.sdi};
            nxt_bit_cnt = 4'(bit_cnt_ff + spi_fr_pkg::CNT_ONE);
            if (bit_cnt_ff == spi_fr_pkg::SPI_BYTE_LAST) begin
              nxt_bit_cnt = '0;
              wr_stb = ~rd_ff; // see [R6]
              nxt_spi_addr = step_addr; // see [R9]
              nxt_out_sh = rd_byte(step_addr);
            end
          end else if (sclk_fall && rd_ff) begin
            nxt_serial_out = out_sh_ff[7]; // see [R7]
            nxt_out_sh = {out_sh_ff[6:0], 1'b0};
            nxt_serial_out_oe = 1'b1; // see [R8]
          end
        end
        default: begin
          nxt_spi_state = spi_fr_pkg::SPI_IDLE;
        end
      endcase
    end
  end

  // register storage written by the serial port
  always_comb begin
    nxt_cfg = cfg_ff;
    if (wr_stb && int'(spi_addr_ff) < CFG_DEPTH) begin
      nxt_cfg[spi_addr_ff[CW-1:0]] = wr_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      spi_state_ff <= spi_fr_pkg::SPI_IDLE;
      bit_cnt_ff <= '0;
      shin_ff <= '0;
      rd_ff <= 1'b0;
      spi_addr_ff <= '0;
      out_sh_ff <= '0;
      serial_out_ff <= 1'b0;
      serial_out_oe_ff <= 1'b0;
      sclk_prev_ff <= 1'b0;
      for (int i = 0; i < CFG_DEPTH; i++) begin
        cfg_ff[i] <= spi_fr_pkg::BYTE_ZERO;
      end
      cfg_ff[spi_fr_pkg::REG_CFG_A[CW-1:0]] <= spi_fr_pkg::CFG_A_RST;
    end else begin
      spi_state_ff <= nxt_spi_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shin_ff <= nxt_shin;
      rd_ff <= nxt_rd;
      spi_addr_ff <= nxt_spi_addr;
      out_sh_ff <= nxt_out_sh;
      serial_out_ff <= nxt_serial_out;
      serial_out_oe_ff <= nxt_serial_out_oe;
      sclk_prev_ff <= sp.sclk;
      cfg_ff <= nxt_cfg;
    end
  end

  // fast port edges
  assign fclk_rise = fp.clk & ~fclk_prev_ff; // see [R11]
  assign fire = fp.sel_n & ~fsel_prev_ff & tsync_ff; // see [R16]
  assign commit = fclk_rise & ~fp.sel_n & (nib_ff == spi_fr_pkg::FAST_HDR_NIB) & hi_ff;
  assign fbyte = {hold_ff, fp.data}; // see [R15]

  // fast header, nibble pairing and byte commit
  always_comb begin
    nxt_nib = nib_ff;
    nxt_hi = hi_ff;
    nxt_hold = hold_ff;
    nxt_fast_addr = fast_addr_ff;
    nxt_tsync = tsync_ff;
    nxt_wok = wok_ff;
    nxt_pend_long = pend_long_ff;
    nxt_pend_phase = pend_phase_ff;
    nxt_mask = mask_ff;
    off = '0;
    if (fp.sel_n) begin
      nxt_nib = '0; // see [R23]
      nxt_hi = 1'b0;
      nxt_tsync = 1'b0;
    end else if (fclk_rise) begin
      if (nib_ff == '0) begin
        nxt_wok = ~fp.data[spi_fr_pkg::WRITE_POS]; // see [R12]
        nxt_tsync = fp.data[spi_fr_pkg::TSYNC_POS];
        nxt_fast_addr = {12'h000, fp.data[1:0]};
        nxt_nib = 3'(nib_ff + spi_fr_pkg::NIB_ONE);
      end else if (nib_ff != spi_fr_pkg::FAST_HDR_NIB) begin
        nxt_fast_addr = {fast_addr_ff[9:0], fp.data};
        nxt_nib = 3'(nib_ff + spi_fr_pkg::NIB_ONE);
      end else if (!hi_ff) begin
        nxt_hold = fp.data;
        nxt_hi = 1'b1;
      end else begin
        nxt_hi = 1'b0;
        nxt_fast_addr = 14'(fast_addr_ff - spi_fr_pkg::FAST_ADDR_ONE); // see [R13]
        if (wok_ff) begin
          if (fast_addr_ff == spi_fr_pkg::ACC_MASK_ADDR) begin
            nxt_mask = fbyte[3:0]; // see [R14]
          end else if (fast_addr_ff >= spi_fr_pkg::LONG_BASE &&
                       fast_addr_ff <= spi_fr_pkg::LONG_END) begin
            off = 14'(fast_addr_ff - spi_fr_pkg::LONG_BASE);
            nxt_pend_long[off[4:3]][off[2:0]] = fbyte; // see [R19]
          end else if (fast_addr_ff >= spi_fr_pkg::PHASE_BASE &&
                       fast_addr_ff <= spi_fr_pkg::PHASE_END) begin
            off = 14'(fast_addr_ff - spi_fr_pkg::PHASE_BASE);
            nxt_pend_phase[off[2:1]][off[0]] = fbyte; // see [R21]
          end else if (fast_addr_ff >= spi_fr_pkg::SHORT_BASE &&
                       fast_addr_ff <= spi_fr_pkg::SHORT_END) begin
            off = 14'(fast_addr_ff - spi_fr_pkg::SHORT_BASE);
            nxt_pend_long[off[3:2]][{1'b1, off[1:0]}] = fbyte; // see [R20]
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      nib_ff <= '0;
      hi_ff <= 1'b0;
      hold_ff <= '0;
      fast_addr_ff <= '0;
      tsync_ff <= 1'b0;
      wok_ff <= 1'b0;
      fclk_prev_ff <= 1'b0;
      fsel_prev_ff <= 1'b1;
      pend_long_ff <= '0;
      pend_phase_ff <= '0;
      mask_ff <= spi_fr_pkg::ACC_MASK_RST;
    end else begin
      nib_ff <= nxt_nib;
      hi_ff <= nxt_hi;
      hold_ff <= nxt_hold;
      fast_addr_ff <= nxt_fast_addr;
      tsync_ff <= nxt_tsync;
      wok_ff <= nxt_wok;
      fclk_prev_ff <= fp.clk;
      fsel_prev_ff <= fp.sel_n;
      pend_long_ff <= nxt_pend_long;
      pend_phase_ff <= nxt_pend_phase;
      mask_ff <= nxt_mask;
    end
  end

  // sync event applies pending words and accumulator resets
  assign sync_evt = (src == spi_fr_pkg::SRC_FAST && fire) ||
                    (src == spi_fr_pkg::SRC_EXT && ext_sync);
  always_comb begin
    nxt_nco_words = nco_words_ff;
    nxt_acc_reset = '0;
    if (sync_evt) begin
      nxt_nco_words.base_word_a = pend_long_ff; // see [R22]
      nxt_nco_words.phase = pend_phase_ff;
      if (fast_en) begin
        nxt_acc_reset = mask_ff; // see [R18]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      nco_words_ff <= '0;
      acc_reset_ff <= '0;
      nco_sync_ff <= 1'b0;
    end else begin
      nco_words_ff <= nxt_nco_words;
      acc_reset_ff <= nxt_acc_reset;
      nco_sync_ff <= sync_evt;
    end
  end

  // outputs, all from flops
  assign serial_out = serial_out_ff;
  assign serial_out_oe = serial_out_oe_ff;
  assign nco_words = nco_words_ff;
  assign nco_acc_reset = acc_reset_ff;
  assign nco_sync = nco_sync_ff;
  assign fast_active = fast_en; // see [R19]

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_out_quiet_hdr: assert property ( // see [R8]
    (spi_state_ff != spi_fr_pkg::SPI_DATA || !rd_ff) |-> !serial_out_oe_ff)
    else $error("serial output driven outside read data");
  a_sel_release: assert property ( // see [R1]
    sp.sel_n |=> (!serial_out_oe_ff && spi_state_ff == spi_fr_pkg::SPI_IDLE))
    else $error("serial port active with select high");
  a_hdr_dir: assert property ( // see [R4]
    (!sp.sel_n && sclk_rise && spi_state_ff == spi_fr_pkg::SPI_HDR &&
     bit_cnt_ff == spi_fr_pkg::SPI_HDR_LAST)
    |=> (spi_state_ff == spi_fr_pkg::SPI_DATA && rd_ff == $past(shin_ff[14])))
    else $error("header end or direction wrong");
  a_wr_store: assert property ( // see [R6]
    (wr_stb && int'(spi_addr_ff) < CFG_DEPTH)
    |=> cfg_ff[$past(spi_addr_ff[CW-1:0])] == $past(wr_byte))
    else $error("write byte not stored");
  a_addr_step: assert property ( // see [R10]
    (wr_stb || (rd_ff && sclk_rise && !sp.sel_n &&
     spi_state_ff == spi_fr_pkg::SPI_DATA && bit_cnt_ff == spi_fr_pkg::SPI_BYTE_LAST))
    |=> spi_addr_ff == $past(step_addr))
    else $error("stream address not stepped");
  a_fast_dec: assert property ( // see [R13]
    commit |=> fast_addr_ff == 14'($past(fast_addr_ff) - spi_fr_pkg::FAST_ADDR_ONE))
    else $error("fast address not decremented");
  a_acc_mask: assert property ( // see [R18]
    sync_evt |=> nco_acc_reset == ($past(fast_en) ? $past(mask_ff) : 4'h0))
    else $error("accumulator reset mismatch");
  a_words_hold: assert property ( // see [R22]
    !sync_evt |=> $stable(nco_words))
    else $error("nco words changed without sync");
  a_fast_fire: assert property ( // see [R16]
    (fire && src == spi_fr_pkg::SRC_FAST) |=> nco_sync ##1 !nco_sync)
    else $error("sync not fired on select release");
endmodule
`default_nettype wire

// [include/spi_fr_pkg.sv]
/*
  shared constants and types for the serial register port and the
  fast reconfiguration port of the nco programming block.
  assumes nothing beyond a systemverilog compiler.
*/
package spi_fr_pkg;
  // serial port framing
  localparam int SPI_ADDR_W = 15;
  localparam logic [3:0] SPI_HDR_LAST = 4'hf;
  localparam logic [3:0] SPI_BYTE_LAST = 4'h7;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [14:0] SPI_ADDR_ONE = 15'h0001;
  // serial register locations and fields
  localparam logic [14:0] REG_CFG_A = 15'h0000;
  localparam logic [14:0] REG_CTRL = 15'h0001;
  localparam int ADDRESS_DIRECTION_BIT_POS = 5;
  localparam int FAST_EN_POS = 0;
  localparam int SRC_POS = 1;
  localparam logic [7:0] CFG_A_RST = 8'h20;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // sync source codes
  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  // fast port framing
  localparam int NCO_N = 4;
  localparam logic [2:0] FAST_HDR_NIB = 3'h4;
  localparam logic [2:0] NIB_ONE = 3'h1;
  localparam logic [13:0] FAST_ADDR_ONE = 14'h0001;
  localparam int WRITE_POS = 3;
  localparam int TSYNC_POS = 2;
  // fast port register map
  localparam logic [13:0] ACC_MASK_ADDR = 14'h00ff;
  localparam logic [13:0] LONG_BASE = 14'h0100;
  localparam logic [13:0] LONG_END = 14'h011f;
  localparam logic [13:0] PHASE_BASE = 14'h0120;
  localparam logic [13:0] PHASE_END = 14'h0127;
  localparam logic [13:0] SHORT_BASE = 14'h0128;
  localparam logic [13:0] SHORT_END = 14'h0137;
  localparam logic [3:0] ACC_MASK_RST = 4'hf;

  typedef enum logic [2:0] {
    SPI_IDLE = 3'b001,
    SPI_HDR = 3'b010,
    SPI_DATA = 3'b100
  } spi_state_t;

  // serial pins as seen after synchronising
  typedef struct packed {
    logic sclk;
    logic sel_n;
    logic sdi;
  } spi_pin_t;

  // fast port pins as seen after synchronising
  typedef struct packed {
    logic clk;
    logic sel_n;
    logic [3:0] data;
  } fast_pin_t;

  // words handed to the nco datapath
  typedef struct packed {
    logic [NCO_N-1:0][63:0] base_word_a;
    logic [NCO_N-1:0][15:0] phase;
  } nco_words_t;
endpackage

// [verilog/sync3.sv]
/*
  three-flop input synchroniser with agreement filter.
  assumes inputs are asynchronous to clk; output moves once the
  second and third stages agree.
*/
`timescale 1ns/1ps
`default_nettype none
module sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // asynchronous in, filtered out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff, nxt_q;

  // take a bit only when the last two stages agree
  always_comb begin
    nxt_q = q_ff;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_q[i] = s3_ff[i];
      end
    end
  end

  // stages, first one read only by the second
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule
`default_nettype wire

// [bench/host_model.sv]
/*
  host side model that drives the serial and fast ports by task calls.
  assumes clk is the system clock; pin edges are four or five clk apart.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // system clock pacing the pins
  input wire logic clk,
  // serial port pins
  output logic sclk,
  output logic ssel_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  // fast port pins
  output logic fclk,
  output logic fsel_n,
  output logic [3:0] fdat
);
  logic [7:0] bytes [0:7];
  logic last_so = 1'b0;
  logic sdo_line;
  // a released line shows the inverse of its last value
  assign sdo_line = sdo_oe ? sdo : ~last_so;
  always @(posedge clk) begin
    if (sdo_oe) begin
      last_so <= sdo;
    end
  end
  // idle pins at time zero, clocks still
  initial begin
    sclk = 1'b0;
    ssel_n = 1'b1;
    sdi = 1'b0;
    fclk = 1'b0;
    fsel_n = 1'b1;
    fdat = 4'h0;
  end
  // one serial bit, driven on the fall, sampled late in the high half
  task automatic sbit(input logic b, input logic exp_oe, inout int bad, output logic o);
    @(posedge clk);
    sclk <= 1'b0;
    sdi <= b;
    repeat (4) @(posedge clk);
    sclk <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    o = sdo_line;
    if (sdo_oe !== exp_oe) bad++;
  endtask
  // direction, address, then n bytes with select held low
  task automatic spi_access(input logic rd, input logic [14:0] addr, input int n,
                            output int bad);
    logic o;
    bad = 0;
    @(posedge clk);
    ssel_n <= 1'b0;
    sbit(rd, 1'b0, bad, o);
    for (int i = 14; i >= 0; i--) sbit(addr[i], 1'b0, bad, o);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        sbit(rd ? 1'b0 : bytes[k][i], rd, bad, o);
        if (rd) bytes[k][i] = o;
      end
    end
    repeat (4) @(posedge clk);
    sclk <= 1'b0;
    repeat (4) @(posedge clk);
    ssel_n <= 1'b1;
    sdi <= ~sdi;
    repeat (12) @(posedge clk);
  endtask
  // one nibble, taken by the device on the rise of fclk
  task automatic fnib(input logic [3:0] v);
    @(posedge clk);
    fclk <= 1'b0;
    fdat <= v;
    repeat (4) @(posedge clk);
    fclk <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // write-only transaction: header nibbles, then bytes high nibble first
  task automatic fast_txn(input logic sync, input logic [13:0] addr, input int n);
    @(posedge clk);
    fsel_n <= 1'b0;
    fnib({1'b0, sync, addr[13:12]});
    fnib(addr[11:8]);
    fnib(addr[7:4]);
    fnib(addr[3:0]);
    for (int k = 0; k < n; k++) begin
      fnib(bytes[k][7:4]);
      fnib(bytes[k][3:0]);
    end
    @(posedge clk);
    fclk <= 1'b0;
    repeat (4) @(posedge clk);
    fsel_n <= 1'b1;
    fdat <= ~fdat;
  endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
/*
  self-checking bench for the nco programming ports.
  assumes host_model paces the pins; registers are reached only by the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [63:0] LW = 64'h0123456789abcdef;
  localparam logic [31:0] SW = 32'hfeedc0de;
  logic clk, nrst, ext_sync, sclk, ssel_n, sdi, sdo, sdo_oe, fclk, fsel_n, nsync, factive;
  logic [3:0] fdat, acc_rst, acc_seen;
  logic seen;
  spi_fr_pkg::nco_words_t words;
  int num_errors, compares, bad;
  // system clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  nco_prog_ports dut_u (.clk(clk), .nrst(nrst), .serial_clk(sclk), .serial_select_n(ssel_n),
    .serial_in(sdi), .serial_out(sdo), .serial_out_oe(sdo_oe), .fast_clk(fclk),
    .fast_port_select_n(fsel_n), .fast_data(fdat), .ext_sync(ext_sync), .nco_words(words),
    .nco_acc_reset(acc_rst), .nco_sync(nsync), .fast_active(factive));
  host_model host_u (.clk(clk), .sclk(sclk), .ssel_n(ssel_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .fclk(fclk), .fsel_n(fsel_n), .fdat(fdat));
  // compare and count
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // single serial write and read
  task automatic spi_wr(input logic [14:0] addr, input logic [7:0] d);
    host_u.bytes[0] = d;
    host_u.spi_access(1'b0, addr, 1, bad);
    check("write oe", 0, bad);
  endtask
  task automatic spi_rd(input logic [14:0] addr, input logic [7:0] exp);
    host_u.spi_access(1'b1, addr, 1, bad);
    check("read oe", 0, bad);
    check("read byte", exp, host_u.bytes[0]);
  endtask
  // bounded watch for a sync pulse and the accumulator reset beside it
  task automatic wait_sync(input logic must, input logic [3:0] exp_acc);
    seen = 1'b0;
    acc_seen = 4'h0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      if (nsync === 1'b1) begin
        seen = 1'b1;
        acc_seen = acc_rst;
      end
    end
    check("sync seen", must, seen);
    if (must) check("acc reset", exp_acc, acc_seen);
    if (must && !seen) test_done();
  endtask
  // main sequence
  initial begin
    nrst = 1'b0;
    ext_sync = 1'b0;
    num_errors = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    spi_rd(15'h0000, 8'h20);
    spi_rd(15'h0001, 8'h00);
    check("fast off", 0, factive);
    $display("test reset done");
    for (int k = 0; k < 3; k++) host_u.bytes[k] = 8'h11 * (k + 1);
    host_u.spi_access(1'b0, 15'h0002, 3, bad);
    host_u.spi_access(1'b1, 15'h0002, 3, bad);
    check("stream oe", 0, bad);
    for (int k = 0; k < 3; k++) check("up byte", 8'h11 * (k + 1), host_u.bytes[k]);
    spi_wr(15'h0000, 8'h00);
    host_u.bytes[0] = 8'h44;
    host_u.bytes[1] = 8'h55;
    host_u.spi_access(1'b0, 15'h0006, 2, bad);
    spi_rd(15'h0006, 8'h44);
    spi_rd(15'h0005, 8'h55);
    spi_rd(15'h0020, 8'h00);
    $display("test serial done");
    spi_wr(15'h0001, 8'h01);
    check("fast on", 1, factive);
    for (int k = 0; k < 8; k++) host_u.bytes[k] = LW[63 - 8 * k -: 8];
    host_u.fast_txn(1'b1, 14'h0107, 8);
    wait_sync(1'b1, 4'hf);
    check("long word", LW, words.base_word_a[0]);
    host_u.bytes[0] = 8'h05;
    host_u.fast_txn(1'b0, 14'h00ff, 1);
    wait_sync(1'b0, 4'h0);
    for (int k = 0; k < 4; k++) host_u.bytes[k] = SW[31 - 8 * k -: 8];
    host_u.fast_txn(1'b0, 14'h012b, 4);
    wait_sync(1'b0, 4'h0);
    check("held word", LW, words.base_word_a[0]);
    host_u.bytes[0] = 8'hab;
    host_u.bytes[1] = 8'hcd;
    host_u.fast_txn(1'b1, 14'h0121, 2);
    wait_sync(1'b1, 4'h5);
    check("short word", {SW, LW[31:0]}, words.base_word_a[0]);
    check("phase word", 16'habcd, words.phase[0]);
    $display("test fast done");
    spi_wr(15'h0001, 8'h03);
    @(posedge clk);
    ext_sync <= 1'b1;
    fork
      begin
        @(posedge clk);
        ext_sync <= 1'b0;
      end
    join_none
    wait_sync(1'b1, 4'h5);
    spi_wr(15'h0001, 8'h00);
    host_u.fast_txn(1'b1, 14'h0121, 2);
    wait_sync(1'b1, 4'h0);
    $display("test sync done");
    test_done();
  end
endmodule
`default_nettype wire
